// file: src/refresh_pkg.sv
// Purpose: shared constants for the staggered burst refresh sequencer
// Assumes: 40 MHz clock, one cpu t-state is two clock cycles
// Notes:   io addresses, field positions, reset values and cycle counts
package refresh_pkg;

  // ==========================================================
  // io ports
  localparam logic [15:0] control_addr      = 16'hfc89;
  localparam logic [15:0] status_addr       = 16'h0061;
  localparam logic [7:0]  control_reset     = 8'h00;
  localparam int          burst_lsb         = 2;
  localparam int          period_lsb        = 0;
  localparam int          toggle_bit        = 4;

  // ==========================================================
  // bank configuration codes
  localparam logic [1:0]  banks_one         = 2'h0;
  localparam logic [1:0]  banks_two         = 2'h1;

  // ==========================================================
  // timing
  localparam int clock_period_ns   = 25;
  localparam int tstate_ns         = 50;
  localparam int tstate_cycles     = tstate_ns / clock_period_ns;
  localparam int half_tstate_cyc   = tstate_cycles / 2;
  localparam int ras_low_halves    = 7;
  localparam int ras_low_cycles    = (ras_low_halves * tstate_ns / 2) / clock_period_ns;
  localparam int precharge_tstates = 2;
  localparam int precharge_cycles  = precharge_tstates * tstate_cycles;
  localparam int row_count         = 1024;
  localparam int base_period_ns    = 4000000;
  localparam int row_interval_cyc  = base_period_ns / (clock_period_ns * row_count);

  // phase marks, in cycles of the strobe, precharge and finish states
  localparam logic [3:0] a_last       = 4'(ras_low_cycles - 1);
  localparam logic [3:0] b_first      = 4'(half_tstate_cyc);
  localparam logic [3:0] b_last       = 4'(half_tstate_cyc + ras_low_cycles - 1);
  localparam logic [3:0] strobe_last  = 4'(half_tstate_cyc + ras_low_cycles);
  localparam logic [3:0] pre_last     = 4'(precharge_cycles - 2);
  localparam logic [3:0] finish_last  = 4'(tstate_cycles - 1);
  localparam logic [9:0] row_reset    = 10'h000;

  typedef enum logic [6:0] {
    st_idle      = 7'b0000001,
    st_hold      = 7'b0000010,
    st_high      = 7'b0000100,
    st_setup     = 7'b0001000,
    st_strobe    = 7'b0010000,
    st_precharge = 7'b0100000,
    st_finish    = 7'b1000000
  } state_t;

endpackage

// file: src/level_sync.sv
// Purpose: two flip-flop synchroniser for a pin level
// Assumes: input is asynchronous to clock
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module level_sync (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic stage;

  // ==========================================================
  // two stages
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage <= 1'b0;
      dout  <= 1'b0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// file: src/interval_timer.sv
// Purpose: free running interval counter giving one-cycle ticks
// Assumes: interval of at least two cycles
// Notes:   a new interval takes effect at once, on the count already running
`timescale 1ns/10ps
module interval_timer (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] interval,
  output logic             tick
);
  logic [15:0] count;
  wire         wrap = (count >= interval - 16'h0001);

  // ==========================================================
  // counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? 16'h0000 : count + 16'h0001;
      tick  <= wrap;
    end
  end
endmodule

// file: src/dram_refresh.sv
// Purpose: row-strobe-only refresh sequencer with hold handshake and bursts
// Assumes: t-state of two clocks, bank_select static while refreshing
// Notes:   control at io fc89, refresh reference bit 4 at io 0061
//
// Behaviour
// - refresh uses row strobes only, never a column strobe
// - raise hold_request and wait for hold_acknowledge before refreshing
// - on acknowledge all row strobes are driven high first
// - then refresh_active_n goes low and the row address is driven
// - strobes 0 and 2 fall first, 1 and 3 half a t-state later
// - one bank pulses strobe 0 only, two banks strobes 0 and 1
// - each strobe stays low 3.5 t-states then rises
// - row counter increments as strobes 0 and 2 rise, kept for next cycle
// - one t-state after strobes 1 and 3 rise last, end request and active
// - control bits 3-2 select 1, 2, 2 or 4 rows per cycle
// - between burst rows advance address, all strobes high two t-states
// - control bits 1-0 select 4, 8, 16 or 32 ms refresh period
// - status bit 4 toggles once per refresh cycle, resets to zero
`timescale 1ns/10ps
module dram_refresh #(
  parameter logic [15:0] row_interval = 16'(refresh_pkg::row_interval_cyc)
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_write,
  input  wire logic        io_read,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  input  wire logic [1:0]  bank_select,
  output logic             hold_request,
  input  wire logic        hold_acknowledge,
  output logic             refresh_active_n,
  output logic [9:0]       dram_address_bus,
  output logic             row_strobe_0_n,
  output logic             row_strobe_1_n,
  output logic             row_strobe_2_n,
  output logic             row_strobe_3_n
);
  import refresh_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [2:0] rows_per_burst(input logic [1:0] sel);
    case (sel)
      2'h0:    rows_per_burst = 3'h1;
      2'h3:    rows_per_burst = 3'h4;
      default: rows_per_burst = 3'h2;
    endcase
  endfunction

  // ==========================================================
  // declarations
  state_t      state;
  state_t      next_state;
  logic [3:0]  phase;
  logic [2:0]  rows_left;
  logic [9:0]  refresh_row;
  logic [7:0]  control;
  logic        pending;
  logic        refresh_toggle;
  logic        strobe_a_n;
  logic        strobe_b_n;
  logic        ack_sync;
  logic        tick;

  wire         control_hit = (io_addr == control_addr);
  wire         status_hit  = (io_addr == status_addr);
  wire [1:0]   burst_sel   = control[burst_lsb +: 2];
  wire [1:0]   period_sel  = control[period_lsb +: 2];
  wire [2:0]   burst_rows  = rows_per_burst(burst_sel);
  wire [15:0]  interval    = (row_interval << period_sel) * {13'h0000, burst_rows};
  wire [3:0]   next_phase  = (next_state != state) ? 4'h0 : phase + 4'h1;
  wire         last_row    = (rows_left == 3'h1);
  wire         strobe_end  = (state == st_strobe) && (phase == strobe_last);
  wire         a_rise      = (state == st_strobe) && (phase == a_last + 4'h1);
  wire         a_low_next  = (state == st_strobe) && (phase <= a_last);
  wire         b_low_next  = (state == st_strobe) && (phase >= b_first) && (phase <= b_last);
  wire         bank_two_up = (bank_select != banks_one);
  wire         bank_four   = (bank_select != banks_one) && (bank_select != banks_two);
  wire         cycle_done  = (state == st_finish) && (phase == finish_last);
  wire [7:0]   read_value  = control_hit ? control :
                             status_hit  ? (8'h00 | (8'(refresh_toggle) << toggle_bit)) : 8'h00;

  // ==========================================================
  // submodules
  level_sync ack_sync_u (
    .clock (clock),
    .rst_b (rst_b),
    .din   (hold_acknowledge),
    .dout  (ack_sync)
  );

  interval_timer timer_u (
    .clock    (clock),
    .rst_b    (rst_b),
    .interval (interval),
    .tick     (tick)
  );

  // ==========================================================
  // row strobe outputs, no column strobe exists
  assign row_strobe_0_n = strobe_a_n;
  assign row_strobe_2_n = strobe_a_n | ~bank_four;
  assign row_strobe_1_n = strobe_b_n | ~bank_two_up;
  assign row_strobe_3_n = strobe_b_n | ~bank_four;

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      st_idle:      if (pending && !ack_sync) next_state = st_hold;
      st_hold:      if (ack_sync) next_state = st_high;
      st_high:      next_state = st_setup;
      st_setup:     next_state = st_strobe;
      st_strobe:    if (strobe_end) next_state = last_row ? st_finish : st_precharge;
      st_precharge: if (phase == pre_last) next_state = st_strobe;
      st_finish:    if (phase == finish_last) next_state = st_idle;
      default:      next_state = st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      phase <= 4'h0;
    end else begin
      state <= next_state;
      phase <= next_phase;
    end
  end

  // request pending, a new tick beats the clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else if (tick) begin
      pending <= 1'b1;
    end else if (state == st_hold) begin
      pending <= 1'b0;
    end
  end

  // hold and refresh indication
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_request     <= 1'b0;
      refresh_active_n <= 1'b1;
    end else begin
      hold_request     <= (next_state != st_idle);
      refresh_active_n <= (next_state == st_idle) || (next_state == st_hold) ||
                          (next_state == st_high);
    end
  end

  // staggered strobes, 3.5 t-states low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strobe_a_n <= 1'b1;
      strobe_b_n <= 1'b1;
    end else begin
      strobe_a_n <= ~a_low_next;
      strobe_b_n <= ~b_low_next;
    end
  end

  // row counter, burst count and address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      refresh_row      <= row_reset;
      rows_left        <= 3'h0;
      dram_address_bus <= row_reset;
    end else begin
      if (a_rise) begin
        refresh_row <= refresh_row + 10'h001;
      end
      if (state == st_high) begin
        rows_left        <= burst_rows;
        dram_address_bus <= refresh_row;
      end else if (strobe_end) begin
        rows_left <= rows_left - 3'h1;
        if (!last_row) begin
          dram_address_bus <= refresh_row;
        end
      end
    end
  end

  // ==========================================================
  // io registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      control        <= control_reset;
      refresh_toggle <= 1'b0;
      io_rdata       <= 8'h00;
    end else begin
      if (io_write && control_hit) begin
        control <= io_wdata;
      end
      if (cycle_done) begin
        refresh_toggle <= ~refresh_toggle;
      end
      if (io_read) begin
        io_rdata <= read_value;
      end
    end
  end

  // ==========================================================
  // assertions
  hold_covers_ref_a: assert property (@(posedge clock) disable iff (!rst_b)
    !refresh_active_n |-> hold_request) else $error("refresh active without hold request");

  high_on_ack_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == st_high |-> strobe_a_n && strobe_b_n) else $error("strobe low at acknowledge");

  ref_before_ras_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(refresh_active_n) |-> strobe_a_n ##2 !strobe_a_n) else $error("refresh active timing wrong");

  stagger_half_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(strobe_a_n) |-> strobe_b_n ##1 !strobe_b_n) else $error("strobe stagger wrong");

  one_bank_a: assert property (@(posedge clock) disable iff (!rst_b)
    bank_select == banks_one |-> row_strobe_1_n && row_strobe_2_n && row_strobe_3_n)
    else $error("extra bank strobed");

  ras_width_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(strobe_a_n) |-> !strobe_a_n [*7] ##1 strobe_a_n) else $error("row strobe width wrong");

  row_inc_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(strobe_a_n) |-> refresh_row == 10'($past(refresh_row) + 10'h001)) else $error("row not incremented");

  end_tstate_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(refresh_active_n) |-> !hold_request && $past(strobe_b_n, 2) && !$past(strobe_b_n, 3))
    else $error("cycle end timing wrong");

  precharge_gap_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(strobe_b_n) && !refresh_active_n ##1 !refresh_active_n && state != st_finish
    |-> strobe_a_n [*3] ##1 !strobe_a_n) else $error("precharge gap wrong");

  toggle_per_cycle_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(refresh_active_n) |-> refresh_toggle != $past(refresh_toggle)) else $error("toggle missing");

  fresh_ack_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(hold_request) |-> !ack_sync)
    else $error("stale acknowledge at new request");

  idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
    !hold_request |-> refresh_active_n && strobe_a_n && strobe_b_n)
    else $error("refresh activity without hold");

  addr_at_ref_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(refresh_active_n) |-> dram_address_bus == refresh_row)
    else $error("row address not driven");

  addr_steady_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == st_strobe |-> $stable(dram_address_bus))
    else $error("row address moved under strobe");

  odd_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    bank_two_up && $fell(row_strobe_0_n) |=> $fell(row_strobe_1_n))
    else $error("strobe 1 not half a t-state later");

  even_pair_a: assert property (@(posedge clock) disable iff (!rst_b)
    bank_four && $fell(row_strobe_0_n) |-> $fell(row_strobe_2_n))
    else $error("strobe 2 not with strobe 0");

  two_bank_a: assert property (@(posedge clock) disable iff (!rst_b)
    bank_select == banks_two |-> row_strobe_2_n && row_strobe_3_n)
    else $error("bank three or four strobed");

  b_width_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(strobe_b_n) |-> !strobe_b_n [*7] ##1 strobe_b_n)
    else $error("late strobe width wrong");

  row_steady_a: assert property (@(posedge clock) disable iff (!rst_b)
    !$rose(strobe_a_n) |-> $stable(refresh_row))
    else $error("row counter moved off strobe rise");

  end_together_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(hold_request) |-> $rose(refresh_active_n))
    else $error("hold and refresh end apart");

  rows_done_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == st_finish |-> rows_left == 3'h0)
    else $error("burst ended early");

  precharge_high_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == st_precharge |-> row_strobe_0_n && row_strobe_1_n && row_strobe_2_n && row_strobe_3_n)
    else $error("strobe low in precharge");

  toggle_once_a: assert property (@(posedge clock) disable iff (!rst_b)
    !cycle_done |=> refresh_toggle == $past(refresh_toggle))
    else $error("toggle outside cycle end");

  tick_pend_a: assert property (@(posedge clock) disable iff (!rst_b)
    tick |=> pending)
    else $error("tick lost");

  burst_four_c: cover property (@(posedge clock) disable iff (!rst_b)
    state == st_high && burst_rows == 3'h4);
  precharge_c: cover property (@(posedge clock) disable iff (!rst_b)
    state == st_precharge);
  cycle_end_c: cover property (@(posedge clock) disable iff (!rst_b)
    cycle_done && bank_four);
  burst_two_c: cover property (@(posedge clock) disable iff (!rst_b)
    state == st_high && burst_rows == 3'h2);
  two_bank_c: cover property (@(posedge clock) disable iff (!rst_b)
    !row_strobe_1_n && row_strobe_2_n);
endmodule

// file: test/host_hold_model.sv
// Purpose: host side of the hold handshake for the refresh sequencer
// Assumes: delay is changed only while hold_request is low
// Notes:   acknowledge follows request after delay plus one cycles
`timescale 1ns/10ps
module host_hold_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [3:0] delay,
  input  wire logic       hold_request,
  output logic            hold_acknowledge
);
  logic [3:0] wait_count;

  // ==========================================================
  // acknowledge after delay, kept until request drops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_acknowledge <= 1'b0;
      wait_count       <= 4'h0;
    end else if (!hold_request) begin
      hold_acknowledge <= 1'b0;
      wait_count       <= 4'h0;
    end else if (wait_count >= delay) begin
      hold_acknowledge <= 1'b1;
    end else begin
      wait_count <= wait_count + 4'h1;
    end
  end
endmodule

// file: test/tb.sv
// Purpose: self-checking bench for the refresh sequencer
// Assumes: row_interval shortened to 40 cycles
// Notes:   every burst code, period code and bank setting is run
`timescale 1ns/10ps
`define check(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module tb;
  import refresh_pkg::*;
  localparam logic [15:0] row_interval = 16'h0028;
  localparam logic [7:0]  ctrl_tab [4] = '{8'h00, 8'h05, 8'h0a, 8'hcf};
  localparam logic [1:0]  bank_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  localparam int          rows_tab [4] = '{1, 2, 2, 4};
  logic        clock, rst_b, io_write, io_read, hold_request, hold_acknowledge, refresh_active_n;
  logic        row_strobe_0_n, row_strobe_1_n, row_strobe_2_n, row_strobe_3_n;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, d;
  logic [1:0]  bank_select;
  logic [3:0]  delay;
  logic [9:0]  dram_address_bus, row;
  int          compares, fail_count, cyc, cycles, start_cyc, t [3];
  wire         all_high = row_strobe_0_n & row_strobe_1_n & row_strobe_2_n & row_strobe_3_n;

  dram_refresh #(.row_interval(row_interval)) dut (.clock(clock), .rst_b(rst_b), .io_addr(io_addr),
    .io_write(io_write), .io_read(io_read), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .bank_select(bank_select), .hold_request(hold_request), .hold_acknowledge(hold_acknowledge),
    .refresh_active_n(refresh_active_n), .dram_address_bus(dram_address_bus),
    .row_strobe_0_n(row_strobe_0_n), .row_strobe_1_n(row_strobe_1_n),
    .row_strobe_2_n(row_strobe_2_n), .row_strobe_3_n(row_strobe_3_n));
  host_hold_model host (.clock(clock), .rst_b(rst_b), .delay(delay), .hold_request(hold_request),
    .hold_acknowledge(hold_acknowledge));

  always #12.5 clock = ~clock;
  always @(posedge clock) cyc++;

  // ==========================================================
  // io access and closing tasks
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
    io_addr = a; io_wdata = v; io_write = 1'b1;
    @(negedge clock);
    io_write = 1'b0;
    @(negedge clock);
  endtask
  task automatic io_rd(input logic [15:0] a);
    io_addr = a; io_read = 1'b1;
    @(negedge clock);
    io_read = 1'b0;
    @(negedge clock);
    d = io_rdata;
  endtask

  // ==========================================================
  // one refresh cycle; rows 0 means count not yet known
  task automatic do_cycle(input int rows, input int banks);
    int n, low0, falls, since, high_run;
    logic prev0, late;
    n = 0; low0 = 0; falls = 0; since = -1; high_run = 0; prev0 = 1'b1;
    while (hold_request !== 1'b1 && n < 4000) begin @(negedge clock); n++; end
    late = (n >= 4000);
    start_cyc = cyc;
    n = 0;
    while (hold_request === 1'b1 && n < 400) begin
      if (hold_acknowledge !== 1'b1) `check(all_high & refresh_active_n, 1'b1)
      if (row_strobe_0_n === 1'b0 && prev0 === 1'b1) begin
        `check(dram_address_bus, row + 10'(falls))
        `check(refresh_active_n, 1'b0)
        if (falls > 0) `check(high_run, precharge_cycles)
        falls++;
      end
      `check(row_strobe_1_n, banks > 0 ? prev0 : 1'b1)
      `check(row_strobe_2_n, banks > 1 ? row_strobe_0_n : 1'b1)
      `check(row_strobe_3_n, banks > 1 ? row_strobe_1_n : 1'b1)
      if (row_strobe_0_n === 1'b1 && prev0 === 1'b0) since = 0;
      else if (since >= 0) since++;
      high_run = all_high ? high_run + 1 : 0;
      low0 += (row_strobe_0_n === 1'b0) ? 1 : 0;
      prev0 = row_strobe_0_n;
      n++;
      @(negedge clock);
    end
    if (late || n >= 400) begin
      fail_count++;
      $display("MISMATCH t=%0t refresh cycle did not finish", $time);
      end_of_test();
    end
    `check(since, half_tstate_cyc + tstate_cycles - 1)
    `check(refresh_active_n, 1'b1)
    if (rows > 0) `check(falls, rows)
    if (rows > 0) `check(low0, ras_low_cycles * rows)
    row = row + 10'(falls);
    cycles++;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0; rst_b = 1'b0; io_addr = 16'h0000; io_write = 1'b0; io_read = 1'b0;
    io_wdata = 8'h00; bank_select = 2'h0; delay = 4'h0; row = row_reset;
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    io_rd(control_addr); `check(d, control_reset)
    io_rd(status_addr); `check(d, 8'h00)
    io_wr(16'hfc88, 8'hff);
    io_wr(status_addr, 8'hff);
    io_rd(control_addr); `check(d, control_reset)
    io_rd(16'h0062); `check(d, 8'h00)
    $display("test reset_and_decode done");
    for (int i = 0; i < 4; i++) begin
      bank_select = bank_tab[i];
      delay = 4'(3 * i);
      io_wr(control_addr, ctrl_tab[i]);
      io_rd(control_addr); `check(d, ctrl_tab[i])
      for (int k = 0; k < 3; k++) begin
        do_cycle(rows_tab[i], int'(bank_tab[i]));
        t[k] = start_cyc;
      end
      `check(t[2] - t[1], (int'(row_interval) << ctrl_tab[i][1:0]) * rows_tab[i])
      io_rd(status_addr); `check(d, 8'(cycles % 2) << toggle_bit)
      $display("test config %0h banks %0d done", ctrl_tab[i], bank_tab[i]);
    end
    end_of_test();
  end
endmodule
